// ===== clcr_cluster.v
// cell cluster: control signal generation, register bus and sixteen cells
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "clcr_map.vh"

module clcr_cluster #(
	parameter N_CELLS     = `CLCR_N_CELLS,
	parameter CHIP_CLR_EN = 1
) (
	input  wire                 clk_i,
	input  wire                 sys_rst_i,
	input  wire [7:0]           addr_i,
	input  wire [31:0]          wr_data_i,
	input  wire                 wr_i,
	input  wire                 rd_i,
	output reg  [31:0]          rd_data_o,
	input  wire [5:0]           row_clk_i,
	input  wire [7:0]           local_ctrl_i,
	input  wire                 chip_wide_clear_n_i,
	input  wire                 chain_i,
	input  wire [4*N_CELLS-1:0] cell_din_i,
	output reg  [N_CELLS-1:0]   cell_q_o,
	output reg  [N_CELLS-1:0]   cell_out_o,
	output reg                  chain_o,
	output reg  [3:0]           ctrl_err_o
);
	reg  [15:0]               src_lo_reg;
	reg  [15:0]               src_hi_reg;
	reg                       pack_reg;
	reg  [N_CELLS-1:0]        clk_sel_reg;
	reg  [N_CELLS-1:0]        clr_sel_reg;
	reg  [N_CELLS-1:0]        preset_reg;
	reg  [N_CELLS-1:0]        chain_reg;
	reg  [N_CELLS-1:0]        bypass_reg;
	reg  [2:0]                err_reg;
	reg  [2:0]                err_next;
	reg  [`CLCR_LUT_BITS-1:0] lut_mem [0:N_CELLS-1];
	reg                       clk_a_prev_reg;
	reg                       clk_b_prev_reg;
	reg  [31:0]               rd_next;
	reg  [15:0]               lo_next;
	reg  [15:0]               hi_next;
	reg                       pack_next;
	reg  [2:0]                chk;
	wire [N_CELLS-1:0]        q;
	wire [N_CELLS-1:0]        comb;
	wire                      clk_a_lvl;
	wire                      clk_b_lvl;
	wire                      gate_a_lvl;
	wire                      gate_b_lvl;
	wire                      clr_a_lvl;
	wire                      clr_b_lvl;
	wire                      sclr_lvl;
	wire                      sload_lvl;
	wire                      sload_used;
	wire                      tick_a;
	wire                      tick_b;
	wire                      chip_clr;
	integer                   r;
	integer                   rr;

	// level of one control from its selected source; unused reads as dflt
	function src_lvl;
		input [2:0] sel;
		input [5:0] row;
		input       loc;
		input       dflt;
		begin
			if (sel < `CLCR_SEL_LOCAL)
				src_lvl = row[sel];
			else if (sel == `CLCR_SEL_LOCAL)
				src_lvl = loc;
			else
				src_lvl = dflt;
		end
	endfunction

	// legality of a control setup: seven in use, four non-global, no pack+load
	function [2:0] cfg_chk;
		input [15:0] lo;
		input [15:0] hi;
		input        pack;
		integer      k;
		reg   [31:0] all;
		reg   [2:0]  s;
		reg   [3:0]  used;
		reg   [3:0]  nong;
		begin
			all  = {hi, lo};
			used = 4'h0;
			nong = 4'h0;
			for (k = 0; k < 8; k = k + 1)
			begin
				s = all[k*4 +: 3];
				if (s != `CLCR_SEL_NONE)
					used = used + 4'h1;
				if (s == `CLCR_SEL_LOCAL)
					nong = nong + 4'h1;
			end
			cfg_chk[`CLCR_E_OVER7]    = (used > `CLCR_MAX_CTRL);
			cfg_chk[`CLCR_E_NONGLOB]  = (nong > `CLCR_MAX_NONGLOB);
			cfg_chk[`CLCR_E_PACKLOAD] = pack &&
				(hi[`CLCR_F_SLOAD +: 3] != `CLCR_SEL_NONE);
		end
	endfunction

	// control levels; each control has its own local routing line
	assign clk_a_lvl  = src_lvl(src_lo_reg[`CLCR_F_CLK_A +: 3], row_clk_i, local_ctrl_i[0], 1'b0);
	assign clk_b_lvl  = src_lvl(src_lo_reg[`CLCR_F_CLK_B +: 3], row_clk_i, local_ctrl_i[1], 1'b0);
	assign gate_a_lvl = src_lvl(src_lo_reg[`CLCR_F_GATE_A +: 3], row_clk_i, local_ctrl_i[2], 1'b1);
	assign gate_b_lvl = src_lvl(src_lo_reg[`CLCR_F_GATE_B +: 3], row_clk_i, local_ctrl_i[3], 1'b1);
	assign clr_a_lvl  = src_lvl(src_hi_reg[`CLCR_F_CLR_A +: 3], row_clk_i, local_ctrl_i[4], 1'b0);
	assign clr_b_lvl  = src_lvl(src_hi_reg[`CLCR_F_CLR_B +: 3], row_clk_i, local_ctrl_i[5], 1'b0);
	assign sclr_lvl   = src_lvl(src_hi_reg[`CLCR_F_SCLR +: 3], row_clk_i, local_ctrl_i[6], 1'b0);
	assign sload_lvl  = src_lvl(src_hi_reg[`CLCR_F_SLOAD +: 3], row_clk_i, local_ctrl_i[7], 1'b0);
	assign sload_used = (src_hi_reg[`CLCR_F_SLOAD +: 3] != `CLCR_SEL_NONE);

	// cluster clocks become enable pulses on the chosen edge of their source;
	// a second clock on the same source with the other edge serves both edges
	assign tick_a = (src_lo_reg[`CLCR_F_CLK_A_FALL] ? (clk_a_prev_reg & ~clk_a_lvl)
		: (~clk_a_prev_reg & clk_a_lvl))
		& (sload_used | gate_a_lvl);
	assign tick_b = (src_lo_reg[`CLCR_F_CLK_B_FALL] ? (clk_b_prev_reg & ~clk_b_lvl)
		: (~clk_b_prev_reg & clk_b_lvl))
		& gate_b_lvl;

	// the chip-wide clear only exists when built in
	assign chip_clr = (CHIP_CLR_EN != 0) & ~chip_wide_clear_n_i;

	// edge history of both cluster clock sources
	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			clk_a_prev_reg <= 1'b0;
			clk_b_prev_reg <= 1'b0;
		end
		else
		begin
			clk_a_prev_reg <= clk_a_lvl;
			clk_b_prev_reg <= clk_b_lvl;
		end
	end

	// proposed control setup; an illegal one is refused whole, not half applied
	always @*
	begin
		lo_next   = src_lo_reg;
		hi_next   = src_hi_reg;
		pack_next = pack_reg;
		if (wr_i && addr_i == `CLCR_OFS_SRC_LO)
			lo_next = wr_data_i[15:0];
		if (wr_i && addr_i == `CLCR_OFS_SRC_HI)
			hi_next = wr_data_i[15:0];
		if (wr_i && addr_i == `CLCR_OFS_MODE)
			pack_next = wr_data_i[0];
		chk = cfg_chk(lo_next, hi_next, pack_next);
		// sticky refusal flags: write one to clear, a new refusal wins
		err_next = err_reg;
		if (wr_i && addr_i == `CLCR_OFS_ERR)
			err_next = err_reg & ~wr_data_i[2:0];
		if (wr_i)
			err_next = err_next | chk;
	end

	// register writes
	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			src_lo_reg  <= `CLCR_RST_SRC;
			src_hi_reg  <= `CLCR_RST_SRC;
			pack_reg    <= 1'b0;
			clk_sel_reg <= {N_CELLS{1'b0}};
			clr_sel_reg <= {N_CELLS{1'b0}};
			preset_reg  <= {N_CELLS{1'b0}};
			chain_reg   <= {N_CELLS{1'b0}};
			bypass_reg  <= {N_CELLS{1'b0}};
			err_reg     <= 3'h0;
		end
		else
		begin
			err_reg <= err_next;
			if (wr_i && chk == 3'h0)
			begin
				src_lo_reg <= lo_next;
				src_hi_reg <= hi_next;
				pack_reg   <= pack_next;
			end
			if (wr_i && addr_i == `CLCR_OFS_CLK_SEL)
				clk_sel_reg <= wr_data_i[N_CELLS-1:0];
			if (wr_i && addr_i == `CLCR_OFS_CLR_SEL)
				clr_sel_reg <= wr_data_i[N_CELLS-1:0];
			if (wr_i && addr_i == `CLCR_OFS_PRESET)
				preset_reg <= wr_data_i[N_CELLS-1:0];
			if (wr_i && addr_i == `CLCR_OFS_CHAIN)
				chain_reg <= wr_data_i[N_CELLS-1:0];
			if (wr_i && addr_i == `CLCR_OFS_BYPASS)
				bypass_reg <= wr_data_i[N_CELLS-1:0];
		end
	end

	// lut truth tables, one word per cell; no reset, software loads them
	always @(posedge clk_i)
	begin
		for (r = 0; r < N_CELLS; r = r + 1)
			if (wr_i && addr_i == (`CLCR_OFS_LUT + r[5:0] * 8'h04))
				lut_mem[r] <= wr_data_i[`CLCR_LUT_BITS-1:0];
	end

	// read mux; unmapped addresses read zero
	always @*
	begin
		rd_next = 32'h0000_0000;
		rr      = 0;
		case (addr_i)
			`CLCR_OFS_SRC_LO:  rd_next[15:0] = src_lo_reg;
			`CLCR_OFS_SRC_HI:  rd_next[15:0] = src_hi_reg;
			`CLCR_OFS_MODE:    rd_next[0] = pack_reg;
			`CLCR_OFS_CLK_SEL: rd_next[N_CELLS-1:0] = clk_sel_reg;
			`CLCR_OFS_CLR_SEL: rd_next[N_CELLS-1:0] = clr_sel_reg;
			`CLCR_OFS_PRESET:  rd_next[N_CELLS-1:0] = preset_reg;
			`CLCR_OFS_CHAIN:   rd_next[N_CELLS-1:0] = chain_reg;
			`CLCR_OFS_BYPASS:  rd_next[N_CELLS-1:0] = bypass_reg;
			`CLCR_OFS_STATUS:  rd_next[N_CELLS-1:0] = q;
			`CLCR_OFS_ERR:     rd_next[3:0] = {sload_used, err_reg};
			default:
			begin
				// own loop index, the write process keeps r to itself
				for (rr = 0; rr < N_CELLS; rr = rr + 1)
					if (addr_i == (`CLCR_OFS_LUT + rr[5:0] * 8'h04))
						rd_next[`CLCR_LUT_BITS-1:0] = lut_mem[rr];
			end
		endcase
	end

	// read data one cycle after the strobe, only in that cycle
	always @(posedge clk_i)
	begin
		if (sys_rst_i)
			rd_data_o <= 32'h0000_0000;
		else if (rd_i)
			rd_data_o <= rd_next;
		else
			rd_data_o <= 32'h0000_0000;
	end

	// the cells; sync clear and load are shared by all of them
	genvar g;
	generate
		for (g = 0; g < N_CELLS; g = g + 1)
		begin : g_cell
			clcr_cell u_cell (
				.clk_i       (clk_i),
				.sys_rst_i   (sys_rst_i),
				.chip_clr_i  (chip_clr),
				.tick_i      (clk_sel_reg[g] ? tick_b : tick_a),
				.aclr_i      (clr_sel_reg[g] ? clr_b_lvl : clr_a_lvl),
				.sclr_i      (sclr_lvl),
				.sload_i     (sload_lvl & ~pack_reg),
				.chain_sel_i (chain_reg[g]),
				.chain_i     ((g == 0) ? chain_i : q[(g == 0) ? 0 : g-1]),
				.preset_i    (preset_reg[g]),
				.lut_i       (lut_mem[g]),
				.din_i       (cell_din_i[4*g +: 4]),
				.q_o         (q[g]),
				.comb_o      (comb[g])
			);
		end
	endgenerate

	// registered cell outputs; bypass shows the lut instead of the register
	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			cell_q_o   <= {N_CELLS{1'b0}};
			cell_out_o <= {N_CELLS{1'b0}};
			chain_o    <= 1'b0;
			ctrl_err_o <= 4'h0;
		end
		else
		begin
			cell_q_o   <= q;
			cell_out_o <= (bypass_reg & comb) | (~bypass_reg & q);
			chain_o    <= q[N_CELLS-1];
			ctrl_err_o <= {sload_used, err_reg};
		end
	end
endmodule // clcr_cluster

`default_nettype wire

// ===== clcr_map.vh
// constants for the cell cluster register control block
`ifndef CLCR_MAP_VH
`define CLCR_MAP_VH

// geometry
`define CLCR_N_CELLS      16
`define CLCR_LUT_BITS     16
`define CLCR_N_ROW        6
`define CLCR_MAX_CTRL     4'd7
`define CLCR_MAX_NONGLOB  4'd4

// register offsets (byte addresses)
`define CLCR_OFS_SRC_LO   8'h00
`define CLCR_OFS_SRC_HI   8'h04
`define CLCR_OFS_MODE     8'h08
`define CLCR_OFS_CLK_SEL  8'h0c
`define CLCR_OFS_CLR_SEL  8'h10
`define CLCR_OFS_PRESET   8'h14
`define CLCR_OFS_CHAIN    8'h18
`define CLCR_OFS_STATUS   8'h1c
`define CLCR_OFS_ERR      8'h20
`define CLCR_OFS_BYPASS   8'h24
`define CLCR_OFS_LUT      8'h40

// source select codes: 0..5 row clock line, 6 local routing, 7 unused
`define CLCR_SEL_LOCAL    3'h6
`define CLCR_SEL_NONE     3'h7

// field positions inside source registers (3-bit select each, the two FALL fields 1-bit edge flags)
`define CLCR_F_CLK_A      0
`define CLCR_F_CLK_A_FALL 3
`define CLCR_F_CLK_B      4
`define CLCR_F_CLK_B_FALL 7
`define CLCR_F_GATE_A     8
`define CLCR_F_GATE_B     12
`define CLCR_F_CLR_A      0
`define CLCR_F_CLR_B      4
`define CLCR_F_SCLR       8
`define CLCR_F_SLOAD      12

// error bits
`define CLCR_E_OVER7      0
`define CLCR_E_NONGLOB    1
`define CLCR_E_PACKLOAD   2
`define CLCR_E_GATEA      3

// reset values
`define CLCR_RST_SRC      16'h7777
`define CLCR_RST_ZERO     16'h0000

`endif

// ===== clcr_cell.v
// one logic cell: four-input lookup function and one programmable register
`timescale 1ns/1ps
`default_nettype none

module clcr_cell (
	input  wire        clk_i,
	input  wire        sys_rst_i,
	input  wire        chip_clr_i,
	input  wire        tick_i,
	input  wire        aclr_i,
	input  wire        sclr_i,
	input  wire        sload_i,
	input  wire        chain_sel_i,
	input  wire        chain_i,
	input  wire        preset_i,
	input  wire [15:0] lut_i,
	input  wire [3:0]  din_i,
	output wire        q_o,
	output wire        comb_o
);
	reg  q_int_reg;
	wire d_sel;
	wire d_int;

	// lut result, also the combinational bypass path
	assign comb_o = lut_i[din_i];
	// register input: own lut or the previous cell's register
	assign d_sel  = chain_sel_i ? chain_i : comb_o;
	// preset by push-back: store the inverse, invert again on the way out
	assign d_int  = preset_i ? ~d_sel : d_sel;
	assign q_o    = preset_i ? ~q_int_reg : q_int_reg;

	// chip clear > cluster clear > sync clear > sync load > data
	always @(posedge clk_i)
	begin
		if (sys_rst_i)
			q_int_reg <= 1'b0;
		else if (chip_clr_i)
			q_int_reg <= 1'b0;
		else if (aclr_i)
			q_int_reg <= 1'b0;
		else if (tick_i)
		begin
			if (sclr_i)
				q_int_reg <= preset_i; // output reads zero either way
			else if (sload_i)
				q_int_reg <= preset_i ? ~din_i[3] : din_i[3];
			else
				q_int_reg <= d_int;
		end
	end
endmodule // clcr_cell

`default_nettype wire

// ===== clcr_checker.sv
// assertion checker for the cell cluster register control block
`timescale 1ns/1ps
`default_nettype none

module clcr_checker #(
	parameter N_CELLS     = 16,
	parameter CHIP_CLR_EN = 1
) (
	input wire logic               clk_i,
	input wire logic               sys_rst_i,
	input wire logic [7:0]         addr_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire logic [31:0]        rd_data_o,
	input wire logic               chip_wide_clear_n_i,
	input wire logic [N_CELLS-1:0] cell_q_o,
	input wire logic               chain_o,
	input wire logic [3:0]         ctrl_err_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// read port: data only right after a strobe, nothing above 16 bits
	a_rd_data_idle: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
		else $error("read data without a read");
	a_rd_upper_zero: assert property (rd_i |=> rd_data_o[31:16] == 16'h0)
		else $error("upper read bits set");
	a_rd_unmapped: assert property (rd_i && addr_i > 8'h7c |=> rd_data_o == 32'h0)
		else $error("unmapped read gave data");
	a_status_copy: assert property (rd_i && addr_i == 8'h1c |=> rd_data_o[15:0] == cell_q_o)
		else $error("status differs from cell outputs");
	// reset leaves the cell register outputs, the chain output and the error flags cleared
	a_reset_clears: assert property ($fell(sys_rst_i) |-> ~|cell_q_o && !chain_o && ctrl_err_o == 4'h0)
		else $error("outputs not cleared by reset");
	// chip clear wins within two edges over ticks and clears, as long as no cell has preset set
	a_chip_clear: assert property (CHIP_CLR_EN != 0 && !chip_wide_clear_n_i |-> ##2 (~|cell_q_o && !chain_o))
		else $error("chip clear did not clear cells");
	a_chain_tail: assert property (chain_o == cell_q_o[N_CELLS-1])
		else $error("chain output is not the last cell");
	// error and load flags move only as the result of a write
	a_err_by_write: assert property ($changed(ctrl_err_o) |-> $past(wr_i) || $past(wr_i, 2))
		else $error("control error flags moved without a write");
endmodule // clcr_checker

bind clcr_cluster clcr_checker #(.N_CELLS(N_CELLS), .CHIP_CLR_EN(CHIP_CLR_EN)) u_checker (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .chip_wide_clear_n_i(chip_wide_clear_n_i),
	.cell_q_o(cell_q_o), .chain_o(chain_o), .ctrl_err_o(ctrl_err_o));

`default_nettype wire

// ===== clcr_tb.sv
// self-checking bench for the cell cluster register control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin err_count++; \
	$display("wrong value %s expected %0h seen %0h", n, e, v); end end

module tb;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wr_data_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [5:0]  row_clk_i = 6'h00;
	logic [7:0]  local_ctrl_i = 8'h00;
	logic        chip_wide_clear_n_i = 1'b1;
	logic        chain_i = 1'b0;
	logic [63:0] cell_din_i = 64'h0;
	wire  [31:0] rd_data_o;
	wire  [15:0] cell_q_o;
	wire  [15:0] cell_out_o;
	wire         chain_o;
	wire  [3:0]  ctrl_err_o;
	logic [31:0] rv;
	logic [31:0] seed = 32'ha75e;
	int          err_count = 0;
	int          checks = 0;
	int          mq = 0;
	int          lw [16];

	clcr_cluster dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .row_clk_i(row_clk_i),
		.local_ctrl_i(local_ctrl_i), .chip_wide_clear_n_i(chip_wide_clear_n_i),
		.chain_i(chain_i), .cell_din_i(cell_din_i), .cell_q_o(cell_q_o),
		.cell_out_o(cell_out_o), .chain_o(chain_o), .ctrl_err_o(ctrl_err_o));

	// 100 ns period
	always #50 clk_i = ~clk_i;

	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// bus cycles: one strobe cycle each, read data caught in the next cycle
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input [7:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rv = rd_data_o;
	endtask

	// one rising edge on row line 0; model shifts only when the gate is open
	task automatic pulse(input bit en);
		seed = lfsr(seed);
		@(posedge clk_i);
		row_clk_i[0] <= 1'b1;
		chain_i <= seed[0];
		cell_din_i <= {seed, ~seed};
		@(posedge clk_i);
		row_clk_i[0] <= 1'b0;
		if (en)
			mq = ((mq << 1) | seed[0]) & 16'hffff;
	endtask

	task automatic status;
		rd(8'h1c);
		`CHK("status", mq[15:0], rv[15:0])
		`CHK("cell out", mq[15:0], cell_out_o)
		`CHK("cell q", mq[15:0], cell_q_o)
	endtask

	// model of every cell's lut for the inputs now driven
	task automatic lut_model;
		for (int i = 0; i < 16; i++)
			mq[i] = lw[i][cell_din_i[4 * i +: 4]];
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard
	initial
	begin
		#3000000;
		err_count++;
		print_verdict;
	end

	// main sequence
	initial
	begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int a = 0; a <= 8'h24; a += 4)
		begin
			rd(a[7:0]);
			`CHK("reset value", (a < 8) ? 32'h7777 : 32'h0, rv)
		end
		rd(8'h30);
		`CHK("hole", 32'h0, rv)
		rd(8'h80);
		`CHK("beyond", 32'h0, rv)
		// four local controls fit, a fifth is refused whole
		wr(8'h00, 32'h6666);
		wr(8'h04, 32'h7776);
		rd(8'h04);
		`CHK("src kept", 32'h7777, rv)
		rd(8'h20);
		`CHK("err local", 3'h2, rv[2:0])
		wr(8'h20, 32'h7);
		// eight controls refused, seven taken
		wr(8'h04, 32'h3210);
		rd(8'h20);
		`CHK("err over", 3'h1, rv[2:0])
		wr(8'h20, 32'h7);
		wr(8'h04, 32'h7210);
		rd(8'h04);
		`CHK("seven taken", 32'h7210, rv)
		// load in use drops gate a and forbids packing
		wr(8'h04, 32'h3777);
		wr(8'h08, 32'h1);
		rd(8'h08);
		`CHK("pack refused", 32'h0, rv)
		`CHK("gate a dropped", 1'b1, ctrl_err_o[3])
		rd(8'h20);
		`CHK("err pack", 3'h4, rv[2:0])
		wr(8'h20, 32'h7);
		// shift chain on cluster clock a from row line 0
		wr(8'h04, 32'h7777);
		wr(8'h00, 32'h7770);
		wr(8'h18, 32'hffff);
		rd(8'h20);
		`CHK("err clear", 4'h0, ctrl_err_o)
		repeat (20) pulse(1);
		status();
		`CHK("chain out", mq[15], chain_o)
		// gate a on row line 1 held low: clock stops
		wr(8'h00, 32'h7170);
		repeat (4) pulse(0);
		status();
		@(posedge clk_i) row_clk_i[1] <= 1'b1;
		repeat (4) pulse(1);
		status();
		// sync clear from local routing waits for a tick, then clears all
		wr(8'h04, 32'h7677);
		@(posedge clk_i) local_ctrl_i[6] <= 1'b1;
		status();
		pulse(0);
		mq = 0;
		@(posedge clk_i) local_ctrl_i[6] <= 1'b0;
		status();
		// cluster clear a needs no tick
		wr(8'h04, 32'h7776);
		repeat (3) pulse(1);
		@(posedge clk_i) local_ctrl_i[4] <= 1'b1;
		@(posedge clk_i) local_ctrl_i[4] <= 1'b0;
		mq = 0;
		status();
		// chip clear beats a tick with data
		repeat (3) pulse(1);
		@(posedge clk_i) chip_wide_clear_n_i <= 1'b0;
		pulse(1);
		@(posedge clk_i) chip_wide_clear_n_i <= 1'b1;
		mq = 0;
		status();
		// random truth tables, seen through the bypass with no tick
		for (int i = 0; i < 16; i++)
		begin
			seed = lfsr(seed);
			lw[i] = seed[15:0];
			wr(8'h40 + 8'h04 * i[7:0], seed);
		end
		wr(8'h24, 32'hffff);
		@(posedge clk_i) cell_din_i <= {seed, ~seed};
		repeat (2) @(posedge clk_i);
		#1 lut_model();
		`CHK("lut out", mq[15:0], cell_out_o)
		wr(8'h24, 32'h0);
		// both edges of row line 0: even cells take the rise, odd the fall
		wr(8'h18, 32'h0);
		wr(8'h0c, 32'haaaa);
		wr(8'h00, 32'h7780);
		pulse(0);
		lut_model();
		status();
		// load on local line 7 ticks past a closed gate a
		wr(8'h0c, 32'h0);
		wr(8'h10, 32'hffff);
		wr(8'h14, 32'h00ff);
		wr(8'h04, 32'h6667);
		wr(8'h00, 32'h7670);
		@(posedge clk_i) local_ctrl_i[7] <= 1'b1;
		pulse(0);
		for (int i = 0; i < 16; i++)
			mq[i] = cell_din_i[4 * i + 3];
		status();
		`CHK("load flag", 1'b1, ctrl_err_o[3])
		// sync clear beats sync load, preset cells read zero too
		@(posedge clk_i) local_ctrl_i[6] <= 1'b1;
		pulse(0);
		mq = 0;
		status();
		// clear line b: preset cells come back reading one
		@(posedge clk_i) local_ctrl_i[7:5] <= 3'b001;
		@(posedge clk_i) local_ctrl_i[5] <= 1'b0;
		mq = 32'h00ff;
		status();
		print_verdict;
	end
endmodule // tb

`default_nettype wire
